// [hdl/job_seq_pkg.sv]
// Function
// - new job only on recipe strobe
// - accumulate requested and measured volume, record
// - end on finish request or timer
// - idle timer restarts on valve off
// - bead requested is flow times duration
// - bead alarms against requested, target check
// - pressure mode alarms against target only
// - zero target disables computed-target error
// - 256 recipes, recipe 0 purges
// - recipe latched at job start
// - static precharge holds pressure while closed
// - closed then opening scaling, timed duration
// - first valve or gateway-selected valve scaling
// - regulator-on delay before opening scaling
// - controller idles strobe, finish, valves low
// - controller waits ready, recipe before strobe
// - strobe reads recipe, sets in-progress
// - controller drives valves, then finish request
// - results published before in-progress clears
// - controller samples results after in-progress drops
// - controller drops finish and strobe after job
// - jobs only while system active
package job_seq_pkg;
	localparam int NUM_RECIPES = 256;
	localparam int RECIPE_W = 8;
	localparam int NUM_VALVES = 4;
	localparam int VOL_W = 24;
	localparam int PCT_W = 8;
	localparam int CMD_W = 16;
	localparam int MS_W = 16;
	localparam int PCT_FULL = 100;
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_IN_NS = 1000000;
	localparam int MS_CYCLES = MS_IN_NS / CLK_PERIOD_NS;
	localparam logic [RECIPE_W-1:0] PURGE_RECIPE = 8'h00;
	// controller register map
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_VALVE = 8'h04;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] REG_VOLUME = 8'h0c;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_FINISH_BIT = 1;
	localparam int CTRL_RECIPE_LSB = 8;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_READY_BIT = 1;
	localparam int ST_INPROG_BIT = 2;
	localparam int ST_DONE_BIT = 3;
	localparam int ST_NOALARM_BIT = 4;
	localparam int ST_NOERROR_BIT = 5;
	localparam int ST_VOLOK_BIT = 6;
	localparam int ST_ERROR_BIT = 7;
	localparam logic [NUM_VALVES-1:0] VALVE_RST = 4'h0;
	localparam logic [RECIPE_W-1:0] RECIPE_RST = 8'h00;
	typedef enum logic [1:0] {MODE_BEAD, MODE_PRESSURE, MODE_OTHER} ctl_mode_e;
	typedef enum logic {END_TIMER, END_GATEWAY} end_mode_e;
	typedef enum logic [1:0] {PRE_OFF, PRE_STATIC, PRE_VALVE1, PRE_GATEWAY}
		pre_mode_e;
endpackage

// [hdl/job_link_if.sv]
`timescale 1ns/1ps
interface job_link_if import job_seq_pkg::*; ();
	logic recipe_strobe;
	logic [RECIPE_W-1:0] recipe_num;
	logic finish_req;
	logic [NUM_VALVES-1:0] valve_on;
	logic plate_ready;
	logic in_progress;
	logic no_alarm;
	logic no_error;
	logic volume_ok;
	logic job_error;
	logic [VOL_W-1:0] dispensed_vol;
	modport device (input recipe_strobe, recipe_num, finish_req, valve_on,
		output plate_ready, in_progress, no_alarm, no_error, volume_ok,
		job_error, dispensed_vol);
	modport ctrl (output recipe_strobe, recipe_num, finish_req, valve_on,
		input plate_ready, in_progress, no_alarm, no_error, volume_ok,
		job_error, dispensed_vol);
endinterface

// [hdl/job_ctrl_end.sv]
`timescale 1ns/1ps
module job_ctrl_end import job_seq_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst_n,
	job_link_if.ctrl link,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata
);
	typedef enum logic [2:0] {C_IDLE, C_SETUP, C_STROBE, C_RUN, C_WAIT,
		C_RELEASE} cstate_e;
	cstate_e state_r;
	logic start_pend_r, finish_pend_r, done_r;
	logic [RECIPE_W-1:0] recipe_req_r, recipe_r;
	logic [NUM_VALVES-1:0] valve_r;
	logic [3:0] result_r;
	logic [VOL_W-1:0] vol_r;
	logic wr_ctrl;

	assign wr_ctrl = wr && addr == REG_CTRL;

	// pending orders from software; a fresh write wins over the clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_pend_r <= 1'b0;
			finish_pend_r <= 1'b0;
			recipe_req_r <= RECIPE_RST;
			valve_r <= VALVE_RST;
		end else begin
			if (wr_ctrl && wdata[CTRL_START_BIT]) begin
				start_pend_r <= 1'b1;
				recipe_req_r <= wdata[CTRL_RECIPE_LSB +: RECIPE_W];
			end else if (state_r == C_SETUP) begin
				start_pend_r <= 1'b0;
			end
			if (wr_ctrl && wdata[CTRL_FINISH_BIT]) begin
				finish_pend_r <= 1'b1;
			end else if (state_r == C_WAIT || state_r == C_IDLE) begin
				finish_pend_r <= 1'b0;
			end
			if (wr && addr == REG_VALVE) begin
				valve_r <= wdata[NUM_VALVES-1:0];
			end
		end
	end

	// job handshake sequence
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= C_IDLE;
			recipe_r <= RECIPE_RST;
			done_r <= 1'b0;
			result_r <= 4'h0;
			vol_r <= '0;
		end else begin
			case (state_r)
				C_IDLE: begin
					if (start_pend_r && link.plate_ready) begin
						recipe_r <= recipe_req_r;
						done_r <= 1'b0;
						state_r <= C_SETUP;
					end
				end
				C_SETUP: state_r <= C_STROBE;
				C_STROBE: begin
					if (link.in_progress) begin
						state_r <= C_RUN;
					end
				end
				C_RUN: begin
					if (!link.in_progress) begin
						state_r <= C_RELEASE;
					end else if (finish_pend_r) begin
						state_r <= C_WAIT;
					end
				end
				C_WAIT: begin
					if (!link.in_progress) begin
						state_r <= C_RELEASE;
					end
				end
				C_RELEASE: begin
					// results only trusted once in-progress is low
					result_r <= {link.job_error, link.volume_ok,
						link.no_error, link.no_alarm};
					vol_r <= link.dispensed_vol;
					done_r <= 1'b1;
					state_r <= C_IDLE;
				end
				default: state_r <= C_IDLE;
			endcase
		end
	end

	// link drive; valves forced low outside a job
	assign link.recipe_num = recipe_r;
	assign link.recipe_strobe = state_r == C_STROBE || state_r == C_RUN ||
		state_r == C_WAIT;
	assign link.finish_req = state_r == C_WAIT;
	assign link.valve_on = (state_r == C_RUN) ? valve_r : '0;

	// register reads, one cycle later
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else if (rd) begin
			case (addr)
				REG_CTRL: rdata <= DATA_W'(recipe_req_r) << CTRL_RECIPE_LSB;
				REG_VALVE: rdata <= DATA_W'(valve_r);
				REG_STATUS: begin
					rdata <= '0;
					rdata[ST_BUSY_BIT] <= state_r != C_IDLE;
					rdata[ST_READY_BIT] <= link.plate_ready;
					rdata[ST_INPROG_BIT] <= link.in_progress;
					rdata[ST_DONE_BIT] <= done_r;
					rdata[ST_ERROR_BIT:ST_NOALARM_BIT] <= result_r;
				end
				REG_VOLUME: rdata <= DATA_W'(vol_r);
				default: rdata <= '0;
			endcase
		end else begin
			rdata <= '0;
		end
	end
endmodule

// [hdl/job_device_end.sv]
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
module job_device_end import job_seq_pkg::*; #(
	parameter int MS_CYCLES_P = MS_CYCLES,
	parameter int RECIPES_P = NUM_RECIPES
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	job_link_if.device link,
	input wire logic system_active,
	input wire ctl_mode_e ctl_mode,
	input wire end_mode_e end_mode,
	input wire pre_mode_e pre_mode,
	input wire logic [MS_W-1:0] idle_ms,
	input wire logic meter_pulse,
	input wire logic [VOL_W-1:0] req_flow,
	input wire logic [CMD_W-1:0] cmd_in,
	input wire logic [CMD_W-1:0] static_press,
	input wire logic [NUM_VALVES-1:0][PCT_W-1:0] closed_scale,
	input wire logic [NUM_VALVES-1:0][PCT_W-1:0] open_scale,
	input wire logic [MS_W-1:0] open_ms,
	input wire logic [MS_W-1:0] reg_on_ms,
	input wire logic [NUM_VALVES-1:0] gw_valve_sel,
	input wire logic cfg_we,
	input wire logic [RECIPE_W-1:0] cfg_idx,
	input wire logic [VOL_W-1:0] cfg_target,
	input wire logic [PCT_W-1:0] cfg_tol_lo,
	input wire logic [PCT_W-1:0] cfg_tol_hi,
	output logic [NUM_VALVES-1:0] valve_drive,
	output logic [CMD_W-1:0] press_cmd,
	output logic rec_valid,
	output logic [RECIPE_W-1:0] rec_recipe,
	output logic [VOL_W-1:0] rec_target,
	output logic [VOL_W-1:0] rec_requested,
	output logic rec_req_avail
);
	typedef enum logic [1:0] {S_IDLE, S_RUN, S_EVAL, S_DONE} state_e;
	typedef enum logic [1:0] {PH_CLOSED, PH_DELAY, PH_OPENING, PH_REGULAR}
		phase_e;
	localparam int WIDE_W = VOL_W + 10;
	if (MS_CYCLES_P < 2 || RECIPES_P < 1 || RECIPES_P > NUM_RECIPES) begin
		$error("job_device_end: bad parameter");
	end
	state_e state_r;
	phase_e phase_r;
	logic [VOL_W-1:0] tgt_mem [RECIPES_P];
	logic [PCT_W-1:0] lo_mem [RECIPES_P];
	logic [PCT_W-1:0] hi_mem [RECIPES_P];
	logic stb_s1_r, stb_s2_r, stb_s3_r, fin_s1_r, fin_s2_r;
	logic armed_r, in_prog_r, start;
	logic [31:0] tick_cnt_r;
	logic ms_tick;
	logic [MS_W:0] idle_cnt_r;
	logic [MS_W-1:0] ph_cnt_r;
	logic [RECIPE_W-1:0] recipe_r;
	logic [VOL_W-1:0] tgt_r, req_acc_r, meas_r;
	logic [PCT_W-1:0] lo_r, hi_r;
	logic any_on, any_on_d_r, job_end;
	logic [VOL_W-1:0] req_vol, alarm_ref;
	logic [1:0] vol_band, tgt_band;
	logic alarm, ct_err;
	// strobe and finish synchronisers; edge taken between stages 2 and 3
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			{stb_s1_r, stb_s2_r, stb_s3_r} <= 3'h0;
			{fin_s1_r, fin_s2_r} <= 2'h0;
		end else begin
			stb_s1_r <= link.recipe_strobe;
			stb_s2_r <= stb_s1_r;
			stb_s3_r <= stb_s2_r;
			fin_s1_r <= link.finish_req;
			fin_s2_r <= fin_s1_r;
		end
	end
	// start only when idle, armed and the system is active
	assign start = state_r == S_IDLE && armed_r && system_active &&
		stb_s2_r && !stb_s3_r;
	// recipe table, one entry per recipe of this plate
	always_ff @(posedge ref_clk) begin
		if (cfg_we && int'(cfg_idx) < RECIPES_P) begin
			tgt_mem[cfg_idx] <= cfg_target;
			lo_mem[cfg_idx] <= cfg_tol_lo;
			hi_mem[cfg_idx] <= cfg_tol_hi;
		end
	end
	// millisecond tick for all user timers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_r <= '0;
		end else if (ms_tick) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h1;
		end
	end
	assign ms_tick = tick_cnt_r == 32'(MS_CYCLES_P - 1);
	// job sequence
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= S_IDLE;
			in_prog_r <= 1'b0;
			armed_r <= 1'b0;
			recipe_r <= RECIPE_RST;
			rec_valid <= 1'b0;
		end else begin
			rec_valid <= 1'b0;
			case (state_r)
				S_IDLE: begin
					if (!fin_s2_r && !stb_s2_r) begin
						armed_r <= 1'b1;
					end
					if (start) begin
						recipe_r <= link.recipe_num;
						in_prog_r <= 1'b1;
						armed_r <= 1'b0;
						state_r <= S_RUN;
					end
				end
				S_RUN: if (job_end) state_r <= S_EVAL;
				S_EVAL: begin
					rec_valid <= 1'b1;
					state_r <= S_DONE;
				end
				S_DONE: begin
					in_prog_r <= 1'b0;
					state_r <= S_IDLE;
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end
	assign link.in_progress = in_prog_r;
	assign link.plate_ready = system_active && armed_r && state_r == S_IDLE;
	// end condition: gateway request or valve-off idle timer
	assign job_end = (end_mode == END_GATEWAY) ? fin_s2_r :
		idle_cnt_r > {1'b0, idle_ms};
	// idle timer, cleared while any valve is on, in whole milliseconds
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_cnt_r <= '0;
		end else if (state_r != S_RUN || any_on) begin
			idle_cnt_r <= '0;
		end else if (ms_tick && !idle_cnt_r[MS_W]) begin
			idle_cnt_r <= idle_cnt_r + 1'b1;
		end
	end
	// recipe fields latched at start; volumes accumulated in the job
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tgt_r <= '0;
			lo_r <= '0;
			hi_r <= '0;
			req_acc_r <= '0;
			meas_r <= '0;
		end else if (start) begin
			tgt_r <= tgt_mem[link.recipe_num];
			lo_r <= lo_mem[link.recipe_num];
			hi_r <= hi_mem[link.recipe_num];
			req_acc_r <= '0;
			meas_r <= '0;
		end else if (state_r == S_RUN) begin
			if (meter_pulse) meas_r <= meas_r + 1'b1;
			if (ms_tick && any_on) begin
				req_acc_r <= req_acc_r + req_flow;
			end
		end
	end
	// tolerance band test: {above high limit, below low limit}
	function automatic logic [1:0] band(input logic [VOL_W-1:0] v,
		input logic [VOL_W-1:0] r, input logic [PCT_W-1:0] lo,
		input logic [PCT_W-1:0] hi);
		logic [WIDE_W-1:0] sv, top, bot;
		sv = WIDE_W'(v) * WIDE_W'(PCT_FULL);
		top = WIDE_W'(r) * (WIDE_W'(PCT_FULL) + WIDE_W'(hi));
		bot = (int'(lo) >= PCT_FULL) ? '0 :
			WIDE_W'(r) * (WIDE_W'(PCT_FULL) - WIDE_W'(lo));
		return {sv > top, sv < bot};
	endfunction
	// evaluation; purge recipe raises nothing
	assign req_vol = (ctl_mode == MODE_BEAD) ? req_acc_r : tgt_r;
	assign alarm_ref = (ctl_mode == MODE_BEAD) ? req_acc_r : tgt_r;
	assign vol_band = band(meas_r, alarm_ref, lo_r, hi_r);
	assign tgt_band = band(req_acc_r, tgt_r, lo_r, hi_r);
	assign alarm = recipe_r != PURGE_RECIPE && |vol_band;
	assign ct_err = ctl_mode == MODE_BEAD && tgt_r != '0 &&
		recipe_r != PURGE_RECIPE && |tgt_band;
	// published results change only in the evaluation cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			link.no_alarm <= 1'b1;
			link.no_error <= 1'b1;
			link.volume_ok <= 1'b1;
			link.job_error <= 1'b0;
			link.dispensed_vol <= '0;
			rec_recipe <= RECIPE_RST;
			rec_target <= '0;
			rec_requested <= '0;
			rec_req_avail <= 1'b0;
		end else if (state_r == S_EVAL) begin
			link.no_alarm <= !alarm;
			link.no_error <= !ct_err;
			link.volume_ok <= !alarm;
			link.job_error <= alarm || ct_err;
			link.dispensed_vol <= meas_r;
			rec_recipe <= recipe_r;
			rec_target <= tgt_r;
			rec_requested <= req_vol;
			rec_req_avail <= ctl_mode != MODE_PRESSURE;
		end
	end
	// valve drive follows requests only inside a job
	assign any_on = |link.valve_on;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			valve_drive <= '0;
			any_on_d_r <= 1'b0;
		end else begin
			valve_drive <= (state_r == S_RUN) ? link.valve_on : '0;
			any_on_d_r <= any_on;
		end
	end
	// precharge phase: closed, regulator-on delay, opening boost, regular
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= PH_CLOSED;
			ph_cnt_r <= '0;
		end else if (!any_on) begin
			phase_r <= PH_CLOSED;
			ph_cnt_r <= '0;
		end else if (!any_on_d_r) begin
			phase_r <= PH_DELAY;
			ph_cnt_r <= '0;
		end else if (ms_tick) begin
			ph_cnt_r <= ph_cnt_r + 1'b1;
			if (phase_r == PH_DELAY && ph_cnt_r + 1'b1 >= reg_on_ms) begin
				phase_r <= PH_OPENING;
				ph_cnt_r <= '0;
			end else if (phase_r == PH_OPENING &&
				ph_cnt_r + 1'b1 >= open_ms) begin
				phase_r <= PH_REGULAR;
			end
		end
	end
	// scaled command; gateway uses the lowest selected valve
	logic [PCT_W-1:0] scale;
	logic [CMD_W+PCT_W-1:0] prod, quot;
	int sel;
	always_comb begin
		sel = 0;
		for (int i = NUM_VALVES - 1; i >= 0; i--) begin
			if (pre_mode == PRE_GATEWAY && gw_valve_sel[i]) sel = i;
		end
		case (phase_r)
			PH_CLOSED, PH_DELAY: scale = closed_scale[sel];
			PH_OPENING: scale = open_scale[sel];
			default: scale = PCT_W'(PCT_FULL);
		endcase
		prod = (CMD_W+PCT_W)'(cmd_in) * (CMD_W+PCT_W)'(scale);
		quot = prod / (CMD_W+PCT_W)'(PCT_FULL);
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			press_cmd <= '0;
		end else if (!in_prog_r || pre_mode == PRE_OFF) begin
			press_cmd <= cmd_in;
		end else if (pre_mode == PRE_STATIC) begin
			press_cmd <= any_on ? cmd_in : static_press;
		end else if (|quot[CMD_W+PCT_W-1:CMD_W]) begin
			press_cmd <= '1; // saturate a boost beyond full scale
		end else begin
			press_cmd <= quot[CMD_W-1:0];
		end
	end
endmodule

// [verification/job_link_properties.sv]
`timescale 1ns/1ps
module job_link_properties import job_seq_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic recipe_strobe,
	input wire logic [RECIPE_W-1:0] recipe_num,
	input wire logic finish_req,
	input wire logic [NUM_VALVES-1:0] valve_on,
	input wire logic plate_ready,
	input wire logic in_progress,
	input wire logic no_alarm,
	input wire logic no_error,
	input wire logic volume_ok,
	input wire logic job_error,
	input wire logic [VOL_W-1:0] dispensed_vol
);
	// one clock domain, so clock and reset are given once
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// start request: ready seen, recipe settled before the strobe
	sequence s_req;
		$rose(recipe_strobe) && plate_ready && $stable(recipe_num);
	endsequence
	sequence s_drop;
		$fell(in_progress);
	endsequence
	// all published results in one vector
	logic [VOL_W+3:0] res;
	assign res = {no_alarm, no_error, volume_ok, job_error, dispensed_vol};
	chk_req_order:
		assert property ($rose(recipe_strobe) |-> s_req)
		else $error("strobe raised before ready or recipe");
	chk_start_lat:
		assert property (s_req |-> ##[2:4] in_progress)
		else $error("job did not start after strobe");
	chk_start_src:
		assert property ($rose(in_progress) |-> $past(recipe_strobe, 2))
		else $error("job started without a strobe");
	chk_busy_ready:
		assert property (in_progress |-> !plate_ready)
		else $error("ready shown during a job");
	chk_rearm_low:
		assert property ($rose(plate_ready) |-> !recipe_strobe &&
			!finish_req && !$past(recipe_strobe, 2) && !$past(finish_req, 2))
		else $error("rearmed before strobe and finish were low");
	chk_result_hold:
		assert property (!in_progress && !$past(in_progress) |-> $stable(res))
		else $error("results changed outside a job");
	chk_drop_late:
		assert property (s_drop |-> $stable(res))
		else $error("results changed with the busy drop");
	chk_flag_pair:
		assert property (volume_ok == no_alarm &&
			job_error == !(no_alarm && no_error))
		else $error("result flags disagree");
	chk_valve_job:
		assert property (|valve_on |-> in_progress)
		else $error("valve request outside a job");
	chk_finish_job:
		assert property ($rose(finish_req) |-> in_progress)
		else $error("finish raised outside a job");
	chk_release:
		assert property (s_drop |-> ##[1:4] !recipe_strobe && !finish_req)
		else $error("strobe or finish kept after job");
endmodule

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top import job_seq_pkg::*; ();
	logic ref_clk, rst_n, wr, rd, system_active, meter_pulse, cfg_we;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, rr, d;
	ctl_mode_e ctl_mode;
	end_mode_e end_mode;
	pre_mode_e pre_mode;
	logic [MS_W-1:0] idle_ms, open_ms, reg_on_ms;
	logic [VOL_W-1:0] req_flow, cfg_target, rec_requested, rec_target, rt;
	logic [CMD_W-1:0] cmd_in, static_press, press_cmd;
	logic [NUM_VALVES-1:0][PCT_W-1:0] closed_scale, open_scale;
	logic [NUM_VALVES-1:0] gw_valve_sel, valve_drive;
	logic [RECIPE_W-1:0] cfg_idx, rec_recipe, rn;
	logic [PCT_W-1:0] cfg_tol_lo, cfg_tol_hi;
	logic rec_valid, rec_req_avail;
	int fails = 0;
	int cmp_count = 0;
	job_link_if lk ();
	job_ctrl_end job_ctrl_end_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.link(lk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata));
	// short ms tick keeps timer and precharge windows brief
	job_device_end #(.MS_CYCLES_P(10)) job_device_end_inst (
		.ref_clk(ref_clk), .rst_n(rst_n), .link(lk),
		.system_active(system_active), .ctl_mode(ctl_mode),
		.end_mode(end_mode), .pre_mode(pre_mode), .idle_ms(idle_ms),
		.meter_pulse(meter_pulse), .req_flow(req_flow), .cmd_in(cmd_in),
		.static_press(static_press), .closed_scale(closed_scale),
		.open_scale(open_scale), .open_ms(open_ms), .reg_on_ms(reg_on_ms),
		.gw_valve_sel(gw_valve_sel), .cfg_we(cfg_we), .cfg_idx(cfg_idx),
		.cfg_target(cfg_target), .cfg_tol_lo(cfg_tol_lo),
		.cfg_tol_hi(cfg_tol_hi), .valve_drive(valve_drive),
		.press_cmd(press_cmd), .rec_valid(rec_valid),
		.rec_recipe(rec_recipe), .rec_target(rec_target),
		.rec_requested(rec_requested), .rec_req_avail(rec_req_avail));
	job_link_properties job_link_properties_inst (.ref_clk(ref_clk),
		.rst_n(rst_n), .recipe_strobe(lk.recipe_strobe),
		.recipe_num(lk.recipe_num), .finish_req(lk.finish_req),
		.valve_on(lk.valve_on), .plate_ready(lk.plate_ready),
		.in_progress(lk.in_progress), .no_alarm(lk.no_alarm),
		.no_error(lk.no_error), .volume_ok(lk.volume_ok),
		.job_error(lk.job_error), .dispensed_vol(lk.dispensed_vol));
	// clock
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// job record, caught on its one-cycle pulse
	always @(posedge ref_clk) begin
		if (rec_valid === 1'b1) begin
			rn <= rec_recipe;
			rt <= rec_target;
			rr <= {rec_req_avail, 7'h00, rec_requested};
		end
	end
	task automatic results();
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge ref_clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rreg(input logic [ADDR_W-1:0] a);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// bounded waits, sampled mid-cycle to stay clear of the edge
	task automatic wip(input logic v);
		for (int n = 0; n < 100 && lk.in_progress !== v; n++)
			@(negedge ref_clk);
		chk({31'h0, lk.in_progress}, {31'h0, v});
	endtask
	task automatic wcmd(input logic [CMD_W-1:0] v);
		for (int n = 0; n < 100 && press_cmd !== v; n++)
			@(negedge ref_clk);
		chk({16'h0, press_cmd}, {16'h0, v});
	endtask
	task automatic cfg(input logic [7:0] i, input logic [23:0] t,
		input logic [7:0] tl);
		@(posedge ref_clk);
		cfg_we <= 1'b1;
		cfg_idx <= i;
		cfg_target <= t;
		cfg_tol_lo <= tl;
		cfg_tol_hi <= tl;
		@(posedge ref_clk);
		cfg_we <= 1'b0;
	endtask
	// whole gateway-ended job; a mid-job control write carries another recipe without the start bit on purpose
	task automatic job(input ctl_mode_e m, input logic [7:0] r, input int p,
		input logic [7:0] e);
		ctl_mode <= m;
		wreg(REG_CTRL, {16'h0, r, 8'h01});
		wip(1'b1);
		wreg(REG_CTRL, {16'h0, ~r, 8'h00});
		wreg(REG_VALVE, 32'h1);
		for (int i = 0; i < p; i++) begin
			@(posedge ref_clk);
			meter_pulse <= 1'b1;
			@(posedge ref_clk);
			meter_pulse <= 1'b0;
		end
		wreg(REG_VALVE, 32'h0);
		wreg(REG_CTRL, {16'h0, r, 8'h02});
		wip(1'b0);
		// controller copies the results two edges after the busy drop
		@(posedge ref_clk);
		rreg(REG_STATUS);
		chk(d & 32'hf4, {24'h0, e});
		rreg(REG_VOLUME);
		chk(d, DATA_W'(p));
		chk({24'h0, rn}, {24'h0, r});
	endtask
	initial begin
		{rst_n, wr, rd, meter_pulse, cfg_we, addr, wdata} = '0;
		{cfg_idx, cfg_target, cfg_tol_lo, cfg_tol_hi} = '0;
		{idle_ms, req_flow, cmd_in, gw_valve_sel} = '0;
		system_active = 1'b1;
		ctl_mode = MODE_OTHER;
		end_mode = END_GATEWAY;
		pre_mode = PRE_OFF;
		static_press = 16'h02bc;
		open_ms = 16'h0003;
		reg_on_ms = 16'h0002;
		closed_scale = {8'h3c, 8'h19, 8'h4b, 8'h32};
		open_scale = {8'h64, 8'h64, 8'h64, 8'h96};
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		cfg(8'h05, 24'd20, 8'd10);
		cfg(8'h03, 24'd1, 8'd100);
		cfg(8'h04, 24'd0, 8'd100);
		cfg(8'h00, 24'd20, 8'd10);
		rreg(REG_STATUS);
		chk(d & 32'hf6, 32'h02);
		rreg(8'h40);
		chk(d, 32'h0);
		req_flow <= 24'd4;
		job(MODE_OTHER, 8'h05, 20, 8'h70);
		chk(rr, 32'h80000014);
		chk({8'h00, rt}, 32'h14);
		job(MODE_OTHER, 8'h05, 10, 8'ha0);
		job(MODE_PRESSURE, 8'h05, 30, 8'ha0);
		chk(rr & 32'h80000000, 32'h0);
		job(MODE_BEAD, 8'h03, 5, 8'hd0);
		job(MODE_BEAD, 8'h04, 5, 8'h70);
		job(MODE_OTHER, 8'h00, 3, 8'h70);
		// held off while inactive, then precharge steps inside one job
		system_active <= 1'b0;
		cmd_in <= 16'h03e8;
		gw_valve_sel <= 4'h4;
		wreg(REG_CTRL, {16'h0, 8'h05, 8'h01});
		repeat (30) @(posedge ref_clk);
		chk({31'h0, lk.in_progress}, 32'h0);
		system_active <= 1'b1;
		wip(1'b1);
		pre_mode <= PRE_STATIC;
		wcmd(16'h02bc);
		pre_mode <= PRE_GATEWAY;
		wcmd(16'h00fa);
		pre_mode <= PRE_VALVE1;
		wcmd(16'h01f4);
		wreg(REG_VALVE, 32'h1);
		// still inside the regulator-on delay, well before two ms ticks
		repeat (4) @(negedge ref_clk);
		chk({16'h0, press_cmd}, 32'h01f4);
		chk({28'h0, valve_drive}, 32'h1);
		wcmd(16'h05dc);
		wcmd(16'h03e8);
		wreg(REG_VALVE, 32'h0);
		wreg(REG_CTRL, {16'h0, 8'h05, 8'h02});
		wip(1'b0);
		// timer end: the second valve-off must restart the count
		end_mode <= END_TIMER;
		idle_ms <= 16'h0002;
		wreg(REG_CTRL, {16'h0, 8'h05, 8'h01});
		wip(1'b1);
		wreg(REG_VALVE, 32'h1);
		wreg(REG_VALVE, 32'h0);
		repeat (15) @(posedge ref_clk);
		wreg(REG_VALVE, 32'h1);
		wreg(REG_VALVE, 32'h0);
		repeat (15) @(posedge ref_clk);
		chk({31'h0, lk.in_progress}, 32'h1);
		wip(1'b0);
		results();
	end
	// watchdog well past the few hundred cycles the tests need
	initial begin
		#400000;
		fails++;
		results();
	end
endmodule
